// file: verilog/secure_region_pkg.sv
package secure_region_pkg;

    // ****************************************************************
    // Command sequence addresses and data.
    // ****************************************************************
    localparam logic [23:0] UNLOCK1_ADDR = 24'h000555;  // First and third unlock word offset.
    localparam logic [23:0] UNLOCK2_ADDR = 24'h0002aa;  // Second unlock word offset.
    localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;    // First unlock data word.
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;    // Second unlock data word.
    localparam logic [15:0] ENTRY_DATA   = 16'h0088;    // Third cycle of the entry command.
    localparam logic [15:0] EXIT_DATA    = 16'h0090;    // Third cycle of the exit command.
    localparam logic [15:0] EXIT_FINAL   = 16'h0000;    // Fourth cycle of the exit command.
    localparam logic [15:0] PROG_DATA    = 16'h00a0;    // Program setup data word.

    // ****************************************************************
    // Secure region layout.
    // ****************************************************************
    localparam int          ADDR_W        = 24;          // Word address width.
    localparam int          SECTOR_BITS   = 16;          // Address bits inside the first sector.
    localparam int          REGION_BITS   = 8;           // Address bits of the 256-word region.
    localparam logic [7:0]  CUSTOMER_BASE = 8'h80;       // First word of the customer area.
    localparam logic        MAP_RESET     = 1'b0;        // Mapping after reset: normal array.

    // ****************************************************************
    // Decoder states, one-hot.
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,  // Waiting for the first unlock cycle.
        ST_UNL1   = 5'b00010,  // First unlock cycle seen.
        ST_UNL2   = 5'b00100,  // Second unlock cycle seen.
        ST_EXIT3  = 5'b01000,  // Exit third cycle seen.
        ST_PROG3  = 5'b10000   // Program setup seen.
    } seq_state_t;

endpackage : secure_region_pkg

// file: verilog/write_match.sv
`timescale 1ns/10ps
// Compares one write cycle against an expected address and data word.
module write_match
    import secure_region_pkg::*;
(
    input  wire logic [ADDR_W-1:0] wr_addr,    // Address of the write.
    input  wire logic [15:0]       wr_data,    // Data of the write.
    input  wire logic [ADDR_W-1:0] exp_addr,   // Expected address.
    input  wire logic [15:0]       exp_data,   // Expected data.
    output logic                   hit         // High when both match.
);

    // ****************************************************************
    // Comparison.
    // ****************************************************************
    // Both address and data must match for the cycle to count.
    assign hit = (wr_addr == exp_addr) && (wr_data == exp_data);

endmodule : write_match

// file: verilog/secure_region_command_decoder.sv
`timescale 1ns/10ps
module secure_region_command_decoder
    import secure_region_pkg::*;
(
    input  wire logic              core_clk,         // Internal device clock.
    input  wire logic              sys_rst,          // Synchronous reset, active high.
    input  wire logic              wr_strobe,        // One-cycle pulse per host write.
    input  wire logic [ADDR_W-1:0] wr_addr,          // Word address of the write.
    input  wire logic [15:0]       wr_data,          // Data word of the write.
    input  wire logic              rd_strobe,        // One-cycle pulse per host read.
    input  wire logic [ADDR_W-1:0] rd_addr,          // Word address of the read.
    input  wire logic              embedded_busy,    // Embedded program or erase running.
    output logic                   secure_map,       // Secure region mapped in.
    output logic                   rd_secure,        // Read is served by the secure region.
    output logic                   rd_invalid,       // Secure read falls outside the 256-word region.
    output logic                   prog_req,         // Pulse: program a customer word.
    output logic [REGION_BITS-1:0] prog_addr,        // Region offset to program.
    output logic [15:0]            prog_data,        // Data word to program.
    output logic                   prog_reject       // Pulse: program target refused.
);

    // ****************************************************************
    // State and comparators.
    // ****************************************************************
    seq_state_t state_q;                 // Command sequence state.
    logic       map_q;                   // Secure mapping flag.
    logic       hit_u1;                  // First unlock cycle matches.
    logic       hit_u2;                  // Second unlock cycle matches.
    logic       hit_entry;               // Entry cycle matches.
    logic       hit_exit;                // Exit third cycle matches.
    logic       hit_prog;                // Program setup matches.
    logic       in_sector;               // Address lies in the first sector.
    logic       in_region;               // Address lies inside 256 words.
    logic       wr_sector;               // Write target lies inside the 256-word region.
    logic       wr_customer;             // Write target lies in customer area.

    write_match u_m1 (.wr_addr(wr_addr), .wr_data(wr_data), .exp_addr(UNLOCK1_ADDR),
                      .exp_data(UNLOCK1_DATA), .hit(hit_u1));
    write_match u_m2 (.wr_addr(wr_addr), .wr_data(wr_data), .exp_addr(UNLOCK2_ADDR),
                      .exp_data(UNLOCK2_DATA), .hit(hit_u2));
    write_match u_m3 (.wr_addr(wr_addr), .wr_data(wr_data), .exp_addr(UNLOCK1_ADDR),
                      .exp_data(ENTRY_DATA), .hit(hit_entry));
    write_match u_m4 (.wr_addr(wr_addr), .wr_data(wr_data), .exp_addr(UNLOCK1_ADDR),
                      .exp_data(EXIT_DATA), .hit(hit_exit));
    write_match u_m5 (.wr_addr(wr_addr), .wr_data(wr_data), .exp_addr(UNLOCK1_ADDR),
                      .exp_data(PROG_DATA), .hit(hit_prog));

    // Sector and region decoding of read and write addresses.
    assign in_sector   = (rd_addr[ADDR_W-1:SECTOR_BITS] == '0);
    assign in_region   = (rd_addr[SECTOR_BITS-1:REGION_BITS] == '0);
    assign wr_sector   = (wr_addr[ADDR_W-1:REGION_BITS] == '0);
    assign wr_customer = wr_sector && (wr_addr[REGION_BITS-1:0] >= CUSTOMER_BASE);

    // ****************************************************************
    // Command sequencer.
    // ****************************************************************
    // Walks the unlock cycles; any mismatch drops back to idle.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else if (wr_strobe) begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= hit_u1 ? ST_UNL1 : ST_IDLE;
                end
                ST_UNL1: begin
                    state_q <= hit_u2 ? ST_UNL2 : ST_IDLE;
                end
                ST_UNL2: begin
                    if (hit_prog && map_q) begin
                        state_q <= ST_PROG3;
                    end else if (hit_exit && map_q) begin
                        state_q <= ST_EXIT3;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    // The fourth cycle always completes or abandons.
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Mapping flag.
    // ****************************************************************
    // Set by entry, cleared only by a full exit or reset.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            map_q <= MAP_RESET;
        end else if (wr_strobe && (state_q == ST_UNL2) && hit_entry) begin
            map_q <= 1'b1;
        end else if (wr_strobe && (state_q == ST_EXIT3) && (wr_data == EXIT_FINAL)) begin
            map_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Program request.
    // ****************************************************************
    // Issues a program only for customer words while embedded_busy is low; others are rejected.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prog_req    <= 1'b0;
            prog_reject <= 1'b0;
            prog_addr   <= '0;
            prog_data   <= '0;
        end else begin
            prog_req    <= 1'b0;
            prog_reject <= 1'b0;
            if (wr_strobe && (state_q == ST_PROG3)) begin
                prog_addr <= wr_addr[REGION_BITS-1:0];
                prog_data <= wr_data;
                if (wr_customer && !embedded_busy) begin
                    prog_req <= 1'b1;
                end else begin
                    prog_reject <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Read steering.
    // ****************************************************************
    // Flags each read that the secure region serves.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            secure_map <= 1'b0;
            rd_secure  <= 1'b0;
            rd_invalid <= 1'b0;
        end else begin
            secure_map <= map_q;
            rd_secure  <= rd_strobe && map_q && in_sector && !embedded_busy;
            rd_invalid <= rd_strobe && map_q && in_sector && !embedded_busy && !in_region;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    sequence s_entry;
        wr_strobe && state_q == ST_UNL2 && hit_entry;
    endsequence

    property p_entry;
        @(posedge core_clk) disable iff (sys_rst) s_entry |=> map_q ##1 secure_map;
    endproperty
    a_entry: assert property (p_entry) else $error("entry did not map region");

    property p_exit;
        @(posedge core_clk) disable iff (sys_rst)
            wr_strobe && state_q == ST_EXIT3 && wr_data == EXIT_FINAL |=> !map_q;
    endproperty
    a_exit: assert property (p_exit) else $error("exit did not unmap region");

    property p_hold;
        @(posedge core_clk) disable iff (sys_rst)
            map_q && !(wr_strobe && state_q == ST_EXIT3) |=> map_q;
    endproperty
    a_hold: assert property (p_hold) else $error("mapping lost early");

    property p_prog;
        @(posedge core_clk) disable iff (sys_rst)
            prog_req |-> $past(state_q) == ST_PROG3 && prog_addr >= CUSTOMER_BASE;
    endproperty
    a_prog: assert property (p_prog) else $error("program outside customer area");

    property p_read;
        @(posedge core_clk) disable iff (sys_rst)
            rd_strobe && map_q && in_sector && !embedded_busy |=> rd_secure;
    endproperty
    a_read: assert property (p_read) else $error("sector read not remapped");

    property p_busy;
        @(posedge core_clk) disable iff (sys_rst) rd_secure |-> $past(!embedded_busy);
    endproperty
    a_busy: assert property (p_busy) else $error("secure read while busy");

    property p_abort;
        @(posedge core_clk) disable iff (sys_rst)
            wr_strobe && state_q == ST_UNL1 && !hit_u2 |=> state_q == ST_IDLE && map_q == $past(map_q);
    endproperty
    a_abort: assert property (p_abort) else $error("mismatch not abandoned");

    property p_reset;
        @(posedge core_clk) sys_rst |=> !map_q && state_q == ST_IDLE;
    endproperty
    a_reset: assert property (p_reset) else $error("reset left mapping");

    property p_invalid;
        @(posedge core_clk) disable iff (sys_rst) rd_invalid |-> rd_secure;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid without remap");

endmodule : secure_region_command_decoder

// file: tb/flash_host_model.sv
`timescale 1ns/10ps
// Host controller model that issues single-cycle write and read strobes.
module flash_host_model
    import secure_region_pkg::*;
(
    input  wire logic         core_clk,   // Device clock.
    output logic              wr_strobe,  // Write pulse.
    output logic [ADDR_W-1:0] wr_addr,    // Write address.
    output logic [15:0]       wr_data,    // Write data.
    output logic              rd_strobe,  // Read pulse.
    output logic [ADDR_W-1:0] rd_addr     // Read address.
);
    // Idle bus at time zero.
    initial begin
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        wr_addr   = '0;
        wr_data   = 16'h0000;
        rd_addr   = '0;
    end
    // One write; released lines flip so stale values never match.
    task automatic write(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(negedge core_clk);
        wr_strobe = 1'b1;
        wr_addr   = a;
        wr_data   = d;
        @(negedge core_clk);
        wr_strobe = 1'b0;
        wr_addr   = ~a;
        wr_data   = ~d;
    endtask : write
    // One read; the address flips once released.
    task automatic read(input logic [ADDR_W-1:0] a);
        @(negedge core_clk);
        rd_strobe = 1'b1;
        rd_addr   = a;
        @(negedge core_clk);
        rd_strobe = 1'b0;
        rd_addr   = ~a;
    endtask : read
    task automatic unlock(input logic [15:0] cmd);
        write(UNLOCK1_ADDR, UNLOCK1_DATA);
        write(UNLOCK2_ADDR, UNLOCK2_DATA);
        write(UNLOCK1_ADDR, cmd);
    endtask : unlock
endmodule : flash_host_model

// file: tb/secure_region_command_decoder_test.sv
`timescale 1ns/10ps
// Self-checking bench for the secure region command decoder.
module secure_region_command_decoder_test
    import secure_region_pkg::*;
;
    logic                   core_clk = 1'b0;   // Device clock.
    logic                   sys_rst  = 1'b1;   // Reset, active high.
    logic                   embedded_busy = 1'b0; // Embedded operation.
    logic                   wr_strobe, rd_strobe, secure_map, rd_secure, rd_invalid;
    logic                   prog_req, prog_reject;
    logic [ADDR_W-1:0]      wr_addr, rd_addr;
    logic [15:0]            wr_data, prog_data;
    logic [REGION_BITS-1:0] prog_addr;
    logic                   map_exp = 1'b0;    // Expected mapping.
    logic [31:0]            seed = 32'd44275;  // Random state.
    int                     err_total = 0;
    int                     checks_done = 0;
    // Clock at 8 ns.
    always #4 core_clk = ~core_clk;
    flash_host_model i_host (.core_clk(core_clk), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_addr(rd_addr));
    secure_region_command_decoder i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .rd_strobe(rd_strobe),
        .rd_addr(rd_addr), .embedded_busy(embedded_busy), .secure_map(secure_map),
        .rd_secure(rd_secure), .rd_invalid(rd_invalid), .prog_req(prog_req),
        .prog_addr(prog_addr), .prog_data(prog_data), .prog_reject(prog_reject));
    // Xorshift generator.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Expected read answer: secure, invalid.
    function automatic logic [1:0] exp_rd(input logic [23:0] a);
        if (!map_exp || embedded_busy || a >= 24'h010000) return 2'b00;
        return {1'b1, a >= 24'h000100};
    endfunction : exp_rd
    // Expected program answer: request, reject.
    function automatic logic [1:0] exp_pg(input logic [23:0] a);
        if (!map_exp) return 2'b00;
        return (!embedded_busy && a >= 24'h80 && a < 24'h100) ? 2'b10 : 2'b01;
    endfunction : exp_pg
    // Flag compare.
    task automatic chk_flag(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_flag
    // Word compare.
    task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    // Mapping is visible one edge after the taking edge.
    task automatic chk_map();
        @(negedge core_clk);
        chk_flag("secure_map", map_exp, secure_map);
    endtask : chk_map
    task automatic do_rd(input logic [23:0] a);
        logic [1:0] e;
        e = exp_rd(a);
        i_host.read(a);
        chk_flag("rd_secure", e[1], rd_secure);
        chk_flag("rd_invalid", e[0], rd_invalid);
    endtask : do_rd
    task automatic do_pg(input logic [23:0] a, input logic [15:0] d);
        logic [1:0] e;
        i_host.unlock(PROG_DATA);
        e = exp_pg(a);
        i_host.write(a, d);
        chk_flag("prog_req", e[1], prog_req);
        chk_flag("prog_reject", e[0], prog_reject);
        if (e[1]) begin
            chk_word("prog_addr", {8'h00, a[7:0]}, {8'h00, prog_addr});
            chk_word("prog_data", d, prog_data);
        end
    endtask : do_pg
    // Verdict and end of run.
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // Watchdog against a hang.
    initial begin
        #(8 * 4000);
        err_total++;
        complete_run();
    end
    // Main sequence.
    initial begin
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        chk_flag("secure_map", 1'b0, secure_map);
        do_pg(24'h000080, 16'h1234);
        do_rd(24'h000040);
        i_host.unlock(ENTRY_DATA);
        map_exp = 1'b1;
        chk_map();
        do_rd(24'h000000);
        do_rd(24'h00ffff);
        do_rd(24'h0000ff);
        do_rd(24'h000100);
        do_rd(24'h010000);
        // Hand-written busy corner: no secure read, program refused.
        embedded_busy = 1'b1;
        do_rd(24'h000010);
        do_pg(24'h000090, 16'h0f0f);
        embedded_busy = 1'b0;
        for (int i = 0; i < 16; i++) begin
            embedded_busy = rnd() % 4 == 0;
            do_rd(24'(rnd() & 32'h1ffff));
            do_pg(24'(rnd() & 32'h1ff), 16'(rnd()));
        end
        embedded_busy = 1'b0;
        do_pg(24'h00007f, 16'h5a5a);
        do_pg(24'h0000ff, 16'ha5a5);
        i_host.write(UNLOCK1_ADDR, UNLOCK1_DATA);
        i_host.write(UNLOCK2_ADDR, UNLOCK2_DATA);
        i_host.write(UNLOCK1_ADDR, 16'h0077);
        chk_map();
        i_host.unlock(EXIT_DATA);
        i_host.write(24'h001234, 16'h0001);
        chk_map();
        i_host.unlock(ENTRY_DATA);
        chk_map();
        i_host.unlock(EXIT_DATA);
        i_host.write(24'(rnd() & 32'hffffff), EXIT_FINAL);
        map_exp = 1'b0;
        chk_map();
        // A wrong second cycle must abandon, so the entry word is ignored.
        i_host.write(UNLOCK1_ADDR, UNLOCK1_DATA);
        i_host.write(24'h0002ab, UNLOCK2_DATA);
        i_host.write(UNLOCK1_ADDR, ENTRY_DATA);
        chk_map();
        do_rd(24'h000040);
        i_host.unlock(ENTRY_DATA);
        map_exp = 1'b1;
        chk_map();
        sys_rst = 1'b1;
        @(negedge core_clk);
        sys_rst = 1'b0;
        map_exp = 1'b0;
        chk_flag("secure_map", 1'b0, secure_map);
        chk_flag("prog_req", 1'b0, prog_req);
        do_rd(24'h000040);
        complete_run();
    end
endmodule : secure_region_command_decoder_test
